// *** wake_pkg.sv ***
// Purpose: Constants and carriers for the processor wake-up message logic
// Assumes: 25 MHz controller clock, 32-bit AXI4-Lite register access
// Notes:   Offsets are byte addresses of aligned words

package wake_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0]  addr_version      = 4'h0;
    localparam logic [3:0]  addr_control      = 4'h4;
    localparam logic [3:0]  addr_status       = 4'h8;
    localparam logic [3:0]  addr_start        = 4'hc;

    // ==========================================================
    // Fields and codes
    localparam logic [2:0]  mode_fixed        = 3'h0;
    localparam logic [2:0]  mode_reset        = 3'h5;
    localparam logic [2:0]  mode_start        = 3'h6;
    localparam int          pos_mode_lo       = 8;
    localparam int          pos_enable        = 0;
    localparam int          pos_integrated    = 1;
    localparam logic [3:0]  type_discrete     = 4'h0;
    localparam logic [3:0]  type_integrated   = 4'h1;
    localparam logic [3:0]  version_minor     = 4'h4; // Arbitrary low digit
    localparam logic [7:0]  own_id_reset      = 8'h00;
    localparam logic [7:0]  broadcast_id      = 8'hff;
    localparam logic [11:0] page_offset       = 12'h000;

    // ==========================================================
    // Timing
    localparam int          clk_mhz           = 25;
    localparam int          reset_pulse_ns    = 200;
    localparam int          reset_pulse_cyc   = (reset_pulse_ns * clk_mhz + 999) / 1000;
    localparam logic [3:0]  reset_pulse_count = 4'(reset_pulse_cyc);

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [7:0] dest;
        logic [2:0] mode;
        logic       edge_trig;
        logic [7:0] vector;
    } message_s;

    typedef struct packed {
        logic       halted;
        logic       real_mode;
        logic [15:0] code_segment;
        logic [15:0] code_offset;
    } cpu_state_s;

endpackage

// *** wake_ipi.sv ***
// Purpose: Target-side handler of reset and start-vector messages
// Assumes: Message bus delivers one-cycle valid strobes on clk
// Notes:   Registers reached over AXI4-Lite; fixed-mode interrupts leave on fixed_pulse and fixed_vector
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.

`timescale 1ns/1ps
`default_nettype none

module wake_ipi
(
    // Clock, reset and enable
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  clk_en,
    // Message bus
    input  wire logic                  msg_valid,
    input  wire wake_pkg::message_s    msg,
    // Processor side
    input  wire logic                  cpu_halted,
    input  wire logic                  cpu_protected,
    output logic                       proc_reset_init,
    output logic                       start_pulse,
    output wake_pkg::cpu_state_s       cpu_load,
    output logic                       fixed_pulse,
    output logic [7:0]                 fixed_vector,
    // AXI4-Lite write
    input  wire logic [3:0]            s_awaddr,
    input  wire logic                  s_awvalid,
    output logic                       s_awready,
    input  wire logic [31:0]           s_wdata,
    input  wire logic [3:0]            s_wstrb,
    input  wire logic                  s_wvalid,
    output logic                       s_wready,
    output logic [1:0]                 s_bresp,
    output logic                       s_bvalid,
    input  wire logic                  s_bready,
    // AXI4-Lite read
    input  wire logic [3:0]            s_araddr,
    input  wire logic                  s_arvalid,
    output logic                       s_arready,
    output logic [31:0]                s_rdata,
    output logic [1:0]                 s_rresp,
    output logic                       s_rvalid,
    input  wire logic                  s_rready
);

    // ==========================================================
    // State declarations
    logic                   aw_held;
    logic                   next_aw_held;
    logic [3:0]             aw_addr;
    logic [3:0]             next_aw_addr;
    logic                   w_held;
    logic                   next_w_held;
    logic [31:0]            w_data;
    logic [31:0]            next_w_data;
    logic [3:0]             w_strb;
    logic [3:0]             next_w_strb;
    logic                   next_bvalid;
    logic [1:0]             next_bresp;
    logic                   next_rvalid;
    logic [31:0]            next_rdata;
    logic [1:0]             next_rresp;
    logic                   ctl_enable;
    logic                   next_ctl_enable;
    logic                   ctl_integrated;
    logic                   next_ctl_integrated;
    logic [7:0]             own_id;
    logic [7:0]             next_own_id;
    logic [3:0]             rst_count;
    logic [3:0]             next_rst_count;
    logic                   next_start_pulse;
    wake_pkg::cpu_state_s   next_cpu_load;
    logic                   next_fixed_pulse;
    logic [7:0]             next_fixed_vector;
    logic [7:0]             last_vector;
    logic [7:0]             next_last_vector;
    logic [7:0]             start_count;
    logic [7:0]             next_start_count;
    logic [7:0]             reset_count;
    logic [7:0]             next_reset_count;
    logic                   wr_fire;
    logic                   addr_hit;
    logic                   start_msg;
    logic                   reset_msg;

    // ==========================================================
    // Message decode
    // Targeted messages need an exact identifier match; broadcast also counts
    assign addr_hit  = (msg.dest == own_id) || (msg.dest == wake_pkg::broadcast_id);
    // Start-vector needs edge trigger and mode 110; enable is not consulted
    assign start_msg = msg_valid && addr_hit && msg.edge_trig
                       && (msg.mode == wake_pkg::mode_start);
    assign reset_msg = msg_valid && addr_hit && (msg.mode == wake_pkg::mode_reset);

    // ==========================================================
    // Message handling next state
    always_comb
    begin
        next_rst_count    = rst_count;
        next_start_pulse  = 1'b0;
        next_cpu_load     = cpu_load;
        next_fixed_pulse  = 1'b0;
        next_fixed_vector = fixed_vector;
        next_last_vector  = last_vector;
        next_start_count  = start_count;
        next_reset_count  = reset_count;
        if (rst_count != 4'h0)
        begin
            next_rst_count = rst_count - 4'h1;
        end
        if (reset_msg)
        begin
            // Only the reset line is driven; caches and FPU stay with the core
            // Firmware reads the shutdown code and warm pointer once the line drops
            next_rst_count   = wake_pkg::reset_pulse_count;
            next_reset_count = reset_count + 8'h01;
        end
        else if (start_msg && ctl_integrated)
        begin
            next_start_pulse            = 1'b1;
            next_last_vector            = msg.vector;
            next_start_count            = start_count + 8'h01;
            next_cpu_load.halted        = 1'b0;
            next_cpu_load.real_mode     = 1'b1;
            next_cpu_load.code_segment  = {msg.vector, 8'h00};
            next_cpu_load.code_offset   = 16'h0000;
        end
        else if (msg_valid && addr_hit && ctl_enable
                 && (msg.mode == wake_pkg::mode_fixed))
        begin
            next_fixed_pulse  = 1'b1;
            next_fixed_vector = msg.vector;
        end
    end

    assign proc_reset_init = (rst_count != 4'h0);

    // ==========================================================
    // Message handling registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rst_count    <= 4'h0;
            start_pulse  <= 1'b0;
            cpu_load     <= '0;
            fixed_pulse  <= 1'b0;
            fixed_vector <= 8'h00;
            last_vector  <= 8'h00;
            start_count  <= 8'h00;
            reset_count  <= 8'h00;
        end
        else if (clk_en)
        begin
            rst_count    <= next_rst_count;
            start_pulse  <= next_start_pulse;
            cpu_load     <= next_cpu_load;
            fixed_pulse  <= next_fixed_pulse;
            fixed_vector <= next_fixed_vector;
            last_vector  <= next_last_vector;
            start_count  <= next_start_count;
            reset_count  <= next_reset_count;
        end
    end

    // ==========================================================
    // AXI4-Lite slave next state
    // Address and data are caught separately so either may come first
    assign s_awready = !aw_held && !s_bvalid;
    assign s_wready  = !w_held && !s_bvalid;
    assign s_arready = !s_rvalid;
    assign wr_fire   = aw_held && w_held && !s_bvalid;

    always_comb
    begin
        next_aw_held        = aw_held;
        next_aw_addr        = aw_addr;
        next_w_held         = w_held;
        next_w_data         = w_data;
        next_w_strb         = w_strb;
        next_bvalid         = s_bvalid;
        next_bresp          = s_bresp;
        next_rvalid         = s_rvalid;
        next_rdata          = s_rdata;
        next_rresp          = s_rresp;
        next_ctl_enable     = ctl_enable;
        next_ctl_integrated = ctl_integrated;
        next_own_id         = own_id;
        if (s_awvalid && s_awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = s_awaddr;
        end
        if (s_wvalid && s_wready)
        begin
            next_w_held = 1'b1;
            next_w_data = s_wdata;
            next_w_strb = s_wstrb;
        end
        if (wr_fire)
        begin
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = 2'b00;
            if (aw_addr == wake_pkg::addr_control)
            begin
                if (w_strb[0])
                begin
                    next_ctl_enable     = w_data[wake_pkg::pos_enable];
                    next_ctl_integrated = w_data[wake_pkg::pos_integrated];
                end
                if (w_strb[1])
                begin
                    next_own_id = w_data[15:8];
                end
            end
            else if (aw_addr != wake_pkg::addr_version && aw_addr != wake_pkg::addr_status
                     && aw_addr != wake_pkg::addr_start)
            begin
                next_bresp = 2'b10;
            end
        end
        else if (s_bvalid && s_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (s_arvalid && s_arready)
        begin
            next_rvalid = 1'b1;
            next_rresp  = 2'b00;
            case (s_araddr)
                wake_pkg::addr_version:
                    // Upper digit tells software which wake technique to use
                    next_rdata = {24'h000000, ctl_integrated ? wake_pkg::type_integrated
                                 : wake_pkg::type_discrete, wake_pkg::version_minor};
                wake_pkg::addr_control:
                    next_rdata = {16'h0000, own_id, 6'h00, ctl_integrated, ctl_enable};
                wake_pkg::addr_status:
                    next_rdata = {14'h0000, cpu_protected, cpu_halted,
                                  reset_count, 7'h00, proc_reset_init};
                wake_pkg::addr_start:
                    next_rdata = {start_count, 4'h0, last_vector, wake_pkg::page_offset};
                default:
                begin
                    next_rdata = 32'h00000000;
                    next_rresp = 2'b10;
                end
            endcase
        end
        else if (s_rvalid && s_rready)
        begin
            next_rvalid = 1'b0;
        end
    end

    // ==========================================================
    // AXI4-Lite slave registers
    // Integrated type by default so start-vector wake works out of reset
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            aw_held        <= 1'b0;
            aw_addr        <= 4'h0;
            w_held         <= 1'b0;
            w_data         <= 32'h00000000;
            w_strb         <= 4'h0;
            s_bvalid       <= 1'b0;
            s_bresp        <= 2'b00;
            s_rvalid       <= 1'b0;
            s_rdata        <= 32'h00000000;
            s_rresp        <= 2'b00;
            ctl_enable     <= 1'b0;
            ctl_integrated <= 1'b1;
            own_id         <= wake_pkg::own_id_reset;
        end
        else if (clk_en)
        begin
            aw_held        <= next_aw_held;
            aw_addr        <= next_aw_addr;
            w_held         <= next_w_held;
            w_data         <= next_w_data;
            w_strb         <= next_w_strb;
            s_bvalid       <= next_bvalid;
            s_bresp        <= next_bresp;
            s_rvalid       <= next_rvalid;
            s_rdata        <= next_rdata;
            s_rresp        <= next_rresp;
            ctl_enable     <= next_ctl_enable;
            ctl_integrated <= next_ctl_integrated;
            own_id         <= next_own_id;
        end
    end

endmodule

`default_nettype wire

// *** wake_ipi_asserts.sv ***
// Purpose: Port-level checker for the wake-up message handler
// Assumes: clk_en never drops while a pulse stands; broadcast stands in for the own id
// Notes:   Bound to wake_ipi from the bench top file
`timescale 1ns/1ps
`default_nettype none
module wake_ipi_asserts
(
    // Clock and reset
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire logic                 clk_en,
    // Message bus
    input wire logic                 msg_valid,
    input wire wake_pkg::message_s   msg,
    // Processor side
    input wire logic                 proc_reset_init,
    input wire logic                 start_pulse,
    input wire wake_pkg::cpu_state_s cpu_load,
    input wire logic                 fixed_pulse,
    // Register bus
    input wire logic                 s_arready,
    input wire logic [31:0]          s_rdata,
    input wire logic                 s_rvalid,
    input wire logic                 s_rready,
    input wire logic                 s_bvalid,
    input wire logic                 s_bready
);
    // ========================================
    // Message handling
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Own id is internal, so only broadcast reset is followed here
    a_reset_hold: assert property (msg_valid && clk_en && msg.mode == wake_pkg::mode_reset
        && msg.dest == wake_pkg::broadcast_id |=> proc_reset_init [*5])
        else $error("reset output not held for five cycles");
    a_reset_cause: assert property ($rose(proc_reset_init) |-> $past(msg_valid)
        && $past(msg.mode) == wake_pkg::mode_reset) else $error("reset without message");
    a_start_cause: assert property (start_pulse |-> $past(msg_valid)
        && $past(msg.mode) == wake_pkg::mode_start && $past(msg.edge_trig))
        else $error("start pulse without start message");
    a_start_load: assert property (start_pulse
        |-> cpu_load == {1'b0, 1'b1, $past(msg.vector), 8'h00, 16'h0000})
        else $error("start pointer wrong");
    // Reset clears the load, so the edge after reset is skipped
    a_load_held: assert property (!start_pulse && !$past(sys_rst) |-> $stable(cpu_load))
        else $error("processor state changed without start");
    a_fixed_cause: assert property (fixed_pulse |-> $past(msg_valid)
        && $past(msg.mode) == wake_pkg::mode_fixed) else $error("fixed pulse without message");
    // ========================================
    // Register bus
    a_read_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata)) // Hold
        else $error("read answer dropped");
    a_read_block: assert property (s_rvalid |-> !s_arready) // Single read
        else $error("read taken while answer pending");
    a_write_hold: assert property (s_bvalid && !s_bready |=> s_bvalid) // Hold
        else $error("write answer dropped");
endmodule
`default_nettype wire

// *** wake_issuer.sv ***
// Purpose: Issuing processor that sends wake-up messages
// Assumes: One message per call, taken on the edge it is held
// Notes:   Released bus shows the inverted last message
`timescale 1ns/1ps
`default_nettype none
module wake_issuer
(
    // Clock and feedback
    input  wire logic          clk,
    input  wire logic          alive,
    // Message bus
    output logic               msg_valid,
    output wake_pkg::message_s msg
);
    logic [7:0]  shutdown_code;
    logic [31:0] warm_vector;
    logic        used_reset;
    // Idle state at time zero
    initial
    begin
        msg_valid = 1'b0;
        msg = '0;
        shutdown_code = 8'h00;
        warm_vector = 32'h0;
        used_reset = 1'b0;
    end
    // Two-processor peer id is bit 0 of our own inverted, with the upper seven bits zero
    function logic [7:0] peer_id(input logic [7:0] own);
        return {7'h00, ~own[0]};
    endfunction
    // One message on the bus for one edge
    task send(input logic [7:0] dest, input logic [2:0] mode, input logic trig,
              input logic [7:0] vv);
        // Reserved start vectors never reach the bus
        if (mode == wake_pkg::mode_start && vv inside {[8'ha0:8'hbf]})
            return;
        @(posedge clk);
        msg_valid <= 1'b1;
        msg <= '{dest, mode, trig, vv};
        @(posedge clk);
        msg_valid <= 1'b0;
        msg <= wake_pkg::message_s'(~msg);
    endtask
    // Broadcast upkeep request; waiting for completion is left to the caller
    task broadcast(input logic [7:0] vv);
        send(wake_pkg::broadcast_id, wake_pkg::mode_fixed, 1'b0, vv);
    endtask
    // No acknowledge exists, so the flag is watched with a timeout
    task wake(input logic [7:0] dest, input logic [7:0] vv, output logic ok);
        int t;
        used_reset = 1'b0;
        ok = 1'b0;
        send(dest, wake_pkg::mode_start, 1'b1, vv);
        for (t = 0; t < 20 && !ok; t++)
        begin
            @(posedge clk);
            ok = alive;
        end
        if (!ok)
        begin
            warm_vector = {vv, 8'h00, 16'h0000};
            shutdown_code = 8'h0a;
            used_reset = 1'b1;
            send(dest, wake_pkg::mode_reset, 1'b0, vv);
            for (t = 0; t < 20 && !ok; t++)
            begin
                @(posedge clk);
                ok = alive;
            end
            shutdown_code = 8'h00;
        end
    endtask
endmodule
`default_nettype wire

// *** processor_wakeup_ipi_logic_bench.sv ***
// Purpose: Self-checking bench for the wake-up message handler
// Assumes: 25 MHz clock, synchronous high reset for 16 cycles
// Notes:   clk_en and s_wstrb each leave their idle value once
`timescale 1ns/1ps
`default_nettype none
module processor_wakeup_ipi_logic_bench;
    logic                 clk, sys_rst, clk_en, cpu_halted, cpu_protected;
    logic                 msg_valid, proc_reset_init, start_pulse, fixed_pulse;
    wake_pkg::message_s   msg;
    wake_pkg::cpu_state_s cpu_load;
    logic [7:0]           fixed_vector;
    logic [3:0]           s_awaddr, s_wstrb, s_araddr;
    logic                 s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
    logic                 s_arvalid, s_arready, s_rvalid, s_rready;
    logic [1:0]           s_bresp, s_rresp, resp;
    logic [31:0]          s_wdata, s_rdata, rd;
    int                   n_errors, n_compared;

    wake_ipi dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .msg_valid(msg_valid),
        .msg(msg), .cpu_halted(cpu_halted), .cpu_protected(cpu_protected),
        .proc_reset_init(proc_reset_init), .start_pulse(start_pulse), .cpu_load(cpu_load),
        .fixed_pulse(fixed_pulse), .fixed_vector(fixed_vector), .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(s_rready));
    wake_issuer iss (.clk(clk), .alive(start_pulse | proc_reset_init),
        .msg_valid(msg_valid), .msg(msg));

    // ========================================
    // Clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ========================================
    // Shared tasks
    task chk(input logic [35:0] got, input logic [35:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Address and data offered together, each dropped once taken
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        s_awaddr  <= a;
        s_wdata   <= d;
        s_awvalid <= 1'b1;
        s_wvalid  <= 1'b1;
        s_bready  <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do
        begin
            @(posedge clk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end
        while (!s_bvalid);
        resp = s_bresp;
        s_bready <= 1'b0;
    endtask
    // Ready comes only once the answer stands, so the slave must hold it
    task rd_reg(input logic [3:0] a);
        @(posedge clk);
        s_araddr  <= a;
        s_arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_arready) s_arvalid <= 1'b0;
            if (s_rvalid && !s_rready) s_rready <= 1'b1;
        end
        while (!(s_rvalid && s_rready));
        rd = s_rdata;
        resp = s_rresp;
        s_rready <= 1'b0;
    endtask
    task stop_test;
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ========================================
    // Scenarios
    task t_regs;
        rd_reg(wake_pkg::addr_version);
        chk(rd, {wake_pkg::type_integrated, wake_pkg::version_minor});
        wr(wake_pkg::addr_version, 32'h0000_00ff);
        chk(resp, 2'h0);
        wr(4'h2, 32'h0000_0000);
        chk(resp, 2'h2);
        rd_reg(wake_pkg::addr_version);
        chk(rd, 32'h14);
        rd_reg(4'h2);
        chk(resp, 2'h2);
        cpu_halted <= 1'b1;
        rd_reg(wake_pkg::addr_status);
        chk(rd[17:16], 2'h1);
    endtask
    // Controller still disabled from reset here
    task t_reset;
        int i;
        iss.send(8'h01, wake_pkg::mode_reset, 1'b0, 8'h00);
        #1;
        chk(proc_reset_init, 1'h0);
        iss.send(8'h00, wake_pkg::mode_fixed, 1'b0, 8'h21);
        #1;
        chk(fixed_pulse, 1'h0);
        iss.send(wake_pkg::own_id_reset, wake_pkg::mode_reset, 1'b0, 8'h00);
        for (i = 0; i < 6; i++)
        begin
            #1;
            chk(proc_reset_init, i < 5);
            @(posedge clk);
        end
        // A frozen block must not take the message at all
        clk_en <= 1'b0;
        iss.send(wake_pkg::own_id_reset, wake_pkg::mode_reset, 1'b0, 8'h00);
        #1;
        chk(proc_reset_init, 1'h0);
        @(posedge clk);
        clk_en <= 1'b1;
        iss.send(wake_pkg::broadcast_id, wake_pkg::mode_reset, 1'b0, 8'h00);
        #1;
        chk(proc_reset_init, 1'h1);
        rd_reg(wake_pkg::addr_status);
        chk(rd[15:8], 8'h02);
    endtask
    task t_start;
        logic [7:0] v [4];
        logic       ok;
        int         i;
        v = '{8'h00, 8'h10, 8'h9f, 8'hff};
        cpu_protected <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            iss.send(8'hff, wake_pkg::mode_start, 1'b1, v[i]);
            #1;
            chk(start_pulse, 1'h1);
            chk(cpu_load, {2'h1, v[i], 24'h0});
        end
        iss.send(8'h00, wake_pkg::mode_start, 1'b0, 8'h40);
        #1;
        chk(start_pulse, 1'h0);
        iss.send(8'h00, 3'h7, 1'b1, 8'h40);
        #1;
        chk(cpu_load, {2'h1, 8'hff, 24'h0});
        iss.wake(wake_pkg::own_id_reset, 8'h30, ok);
        chk({ok, iss.used_reset}, 2'h2);
        rd_reg(wake_pkg::addr_start);
        chk(rd, 32'h0503_0000);
    endtask
    // Discrete controller with own id 1 and enabled
    task t_discrete;
        logic ok;
        wr(wake_pkg::addr_control, 32'h0000_0101);
        rd_reg(wake_pkg::addr_version);
        chk(rd, {wake_pkg::type_discrete, wake_pkg::version_minor});
        iss.send(8'h01, wake_pkg::mode_fixed, 1'b0, 8'h21);
        #1;
        chk({fixed_pulse, fixed_vector}, 9'h121);
        iss.wake(iss.peer_id(8'h00), 8'h20, ok);
        chk({ok, iss.used_reset}, 2'h3);
        chk(cpu_load, {2'h1, 8'h30, 24'h0});
        iss.broadcast(8'h41);
        #1;
        chk({fixed_pulse, fixed_vector}, 9'h141);
        // Status read first, as a handler does before servicing
        rd_reg(wake_pkg::addr_status);
        chk(rd[17:16], 2'h3);
        // Let the last reset pulse run out before the peer is shut down
        repeat (6) @(posedge clk);
        iss.wake(iss.peer_id(8'h00), 8'h50, ok);
        chk({ok, iss.used_reset}, 2'h3);
        // Byte lane 1 alone moves only the identifier
        s_wstrb <= 4'h2;
        wr(wake_pkg::addr_control, 32'h0000_0200);
        rd_reg(wake_pkg::addr_control);
        chk(rd, 32'h0000_0201);
    endtask
    // ========================================
    // Main sequence and watchdog
    initial
    begin
        {sys_rst, clk_en, cpu_halted, cpu_protected} = 4'hc;
        {s_awaddr, s_araddr, s_wdata, s_wstrb} = {8'h00, 32'h0, 4'hf};
        {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
        n_errors = 0;
        n_compared = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs;
        t_reset;
        t_start;
        t_discrete;
        stop_test;
    end
    initial
    begin
        #100000;
        n_errors++;
        stop_test;
    end
endmodule
bind wake_ipi wake_ipi_asserts watch (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .msg_valid(msg_valid), .msg(msg), .proc_reset_init(proc_reset_init),
    .start_pulse(start_pulse), .cpu_load(cpu_load), .fixed_pulse(fixed_pulse),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .s_bvalid(s_bvalid), .s_bready(s_bready));
`default_nettype wire
